// ===== cpdm_core.sv
/*
  Decode and execute unit for the data-transfer instruction group, with the
  register file, status register and a data-bus master port.
  Assumes fetch presents one halfword per handshake, the data bus holds ack
  for one cycle per request, and inputs are synchronous to sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module cpdm_core #(
  parameter int CW = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // instruction fetch
  input wire cpdm_pkg::cpdm_fetch_t fetch,
  input wire logic fetch_busy,
  output logic fetch_ready,
  // data bus
  output cpdm_pkg::cpdm_mreq_t mem_req,
  input wire cpdm_pkg::cpdm_mrsp_t mem_rsp,
  // status and completion
  output logic [31:0] status_reg,
  output logic insn_done,
  output logic [CW-1:0] insn_cycles,
  output logic undef_insn,
  output logic dsp_issue,
  output logic [3:0] dsp_ops,
  // register observation
  input wire logic [3:0] dbg_sel,
  output logic [31:0] dbg_data
);
  import cpdm_pkg::*;

  typedef struct packed {
    cpdm_state_t fsm;
    logic rdy;
    logic [NREG-1:0][XLEN-1:0] regs;
    logic [15:0] insn;
    logic [XLEN-1:0] pc;
    cpdm_mreq_t mem;
    logic ld;
    logic [3:0] ld_dst;
    logic haz;
    logic [3:0] haz_reg;
    logic [31:0] sr;
    logic [CW-1:0] cnt;
    logic done;
    logic [CW-1:0] cyc;
    logic undef;
    logic dsp;
    logic [3:0] dsp_ops;
    logic [31:0] dbg;
  } cpdm_st_t;

  cpdm_st_t st;
  cpdm_st_t next_st;

  // loaded operand widened by size
  function automatic logic [31:0] cpdm_sext(cpdm_size_t sz, logic [31:0] d);
    unique case (sz)
      SZ_B: cpdm_sext = {{24{d[7]}}, d[7:0]};
      SZ_W: cpdm_sext = {{16{d[15]}}, d[15:0]};
      default: cpdm_sext = d;
    endcase
  endfunction : cpdm_sext

  // displacement or step scaled by operand size
  function automatic logic [31:0] cpdm_scale(logic [7:0] d, cpdm_size_t sz);
    logic [31:0] w;
    w = {24'h000000, d};
    cpdm_scale = w << sz;
  endfunction : cpdm_scale

  // conservative: both register fields count as a read, implicit zero only for indexed and short-displacement forms; immediate and PC-relative forms count none
  function automatic logic cpdm_reads(logic [15:0] i, logic [3:0] r);
    logic hit;
    hit = (r == i[11:8]) || (r == i[7:4]);
    if (i[15:12] == OPC_IDX || i[15:12] == OPC_DSH) begin
      hit = hit || (r == REG_ZERO);
    end
    if (i[15:12] == OPC_IMM || i[15:12] == OPC_PCW || i[15:12] == OPC_PCL) begin
      hit = 1'b0;
    end
    cpdm_reads = hit;
  endfunction : cpdm_reads

  logic exec;
  logic mem_op;
  logic [15:0] cur;
  logic [31:0] cpc;
  logic [3:0] rn;
  logic [3:0] rm;
  cpdm_size_t sz;
  logic [31:0] ea;

  // next-state: decode, execute, bus sequencing
  always_comb begin
    next_st = st;
    exec = 1'b0;
    mem_op = 1'b0;
    cur = st.insn;
    cpc = st.pc;
    ea = WORD_ZERO;
    next_st.done = 1'b0;
    next_st.undef = 1'b0;
    next_st.dsp = 1'b0;
    next_st.dbg = st.regs[dbg_sel];
    unique case (st.fsm)
      S_IDLE: begin
        next_st.haz = 1'b0; // penalty only for the very next instruction
        if (fetch.valid && st.rdy) begin
          next_st.insn = fetch.insn;
          next_st.pc = fetch.pc;
          next_st.cnt = CW'(CYC_ONE);
          if (st.haz && cpdm_reads(fetch.insn, st.haz_reg)) begin
            next_st.fsm = S_STALL;
          end else begin
            exec = 1'b1;
            cur = fetch.insn;
            cpc = fetch.pc;
          end
        end
      end
      S_STALL: begin
        next_st.cnt = st.cnt + CW'(CYC_ONE);
        exec = 1'b1;
      end
      S_EXT: begin
        if (fetch.valid && st.rdy) begin
          // second halfword: X/Y move, ALU and multiply slots
          next_st.dsp_ops = {|fetch.insn[15:12], |fetch.insn[11:8],
                             |fetch.insn[7:4], |fetch.insn[3:0]};
          next_st.dsp = 1'b1;
          next_st.done = 1'b1;
          next_st.cyc = st.cnt;
          next_st.fsm = S_IDLE;
        end
      end
      S_MEM: begin
        next_st.cnt = st.cnt + CW'(CYC_ONE);
        if (!st.mem.req) begin
          next_st.mem.req = !fetch_busy;
        end else if (mem_rsp.ack) begin
          next_st.mem.req = 1'b0;
          next_st.done = 1'b1;
          next_st.cyc = next_st.cnt; // ack cycle counts, as a stall cycle does
          next_st.fsm = S_IDLE;
          if (st.ld) begin
            next_st.regs[st.ld_dst] = cpdm_sext(st.mem.size, mem_rsp.rdata);
            next_st.haz = 1'b1;
            next_st.haz_reg = st.ld_dst;
          end
        end
      end
      default: begin
        next_st.fsm = S_IDLE;
      end
    endcase
    rn = cur[11:8];
    rm = cur[7:4];
    sz = cpdm_size_t'(cur[1:0]);
    if (exec) begin
      // one halfword per base instruction; status flag untouched
      next_st.done = 1'b1;
      next_st.cyc = next_st.cnt;
      next_st.fsm = S_IDLE;
      next_st.mem.we = 1'b0;
      next_st.mem.wdata = WORD_ZERO;
      next_st.ld = 1'b0;
      next_st.ld_dst = rn;
      unique case (cur[15:12])
        OPC_IMM: begin
          next_st.regs[rn] = {{24{cur[7]}}, cur[7:0]};
        end
        OPC_PCW: begin
          mem_op = 1'b1;
          next_st.ld = 1'b1;
          sz = SZ_W;
          ea = cpc + cpdm_scale(cur[7:0], SZ_W);
        end
        OPC_PCL: begin
          mem_op = 1'b1;
          next_st.ld = 1'b1;
          sz = SZ_L;
          ea = cpc + cpdm_scale(cur[7:0], SZ_L);
        end
        OPC_STR: begin
          mem_op = (sz != SZ_RSV) && (cur[3:2] == LO_PLAIN || cur[3:2] == LO_STEP);
          next_st.mem.we = 1'b1;
          next_st.mem.wdata = st.regs[rm];
          ea = st.regs[rn];
          if (cur[3:2] == LO_STEP) begin
            ea = st.regs[rn] - cpdm_scale(8'h01, sz);
            if (mem_op) begin
              next_st.regs[rn] = ea;
            end
          end
        end
        OPC_LDR: begin
          if (cur[3:0] == LO_MOVE) begin
            next_st.regs[rn] = st.regs[rm];
          end else begin
            mem_op = (sz != SZ_RSV) && (cur[3:2] == LO_PLAIN || cur[3:2] == LO_STEP);
            next_st.ld = 1'b1;
            ea = st.regs[rm];
            if (mem_op && cur[3:2] == LO_STEP) begin
              // a load into the same register lands later and wins
              next_st.regs[rm] = st.regs[rm] + cpdm_scale(8'h01, sz);
            end
          end
        end
        OPC_IDX: begin
          if (cur[3:2] == LO_STEP) begin
            mem_op = (sz != SZ_RSV);
            next_st.mem.we = 1'b1;
            next_st.mem.wdata = st.regs[rm];
            ea = st.regs[REG_ZERO] + st.regs[rn];
          end else begin
            mem_op = (sz != SZ_RSV) && (cur[3:2] == LO_IDXLD);
            next_st.ld = 1'b1;
            ea = st.regs[REG_ZERO] + st.regs[rm];
          end
        end
        OPC_DSH: begin
          sz = (cur[11:8] == SUB_STW || cur[11:8] == SUB_LDW) ? SZ_W : SZ_B;
          ea = st.regs[rm] + cpdm_scale({4'h0, cur[3:0]}, sz);
          mem_op = (cur[11:8] == SUB_STB) || (cur[11:8] == SUB_STW) ||
                   (cur[11:8] == SUB_LDB) || (cur[11:8] == SUB_LDW);
          next_st.ld = (cur[11:8] == SUB_LDB) || (cur[11:8] == SUB_LDW);
          next_st.ld_dst = REG_ZERO;
          next_st.mem.we = !next_st.ld;
          next_st.mem.wdata = st.regs[REG_ZERO];
        end
        OPC_LST: begin
          mem_op = 1'b1;
          sz = SZ_L;
          next_st.mem.we = 1'b1;
          next_st.mem.wdata = st.regs[rm];
          ea = st.regs[rn] + cpdm_scale({4'h0, cur[3:0]}, SZ_L);
        end
        OPC_LLD: begin
          mem_op = 1'b1;
          sz = SZ_L;
          next_st.ld = 1'b1;
          ea = st.regs[rm] + cpdm_scale({4'h0, cur[3:0]}, SZ_L);
        end
        OPC_DSP: begin
          if (cur[11:10] == DSP_PAR) begin
            next_st.done = 1'b0;
            next_st.fsm = S_EXT;
            next_st.cnt = next_st.cnt + CW'(CYC_ONE);
          end else begin
            next_st.dsp = 1'b1;
            next_st.dsp_ops = 4'h0;
          end
        end
        default: begin
          next_st.undef = 1'b1;
        end
      endcase
      if (mem_op) begin
        next_st.done = 1'b0;
        next_st.fsm = S_MEM;
        next_st.mem.size = sz;
        next_st.mem.addr = ea;
        next_st.mem.req = !fetch_busy;
      end else if (cur[15:12] != OPC_IMM && cur[15:12] != OPC_DSP &&
                   !(cur[15:12] == OPC_LDR && cur[3:0] == LO_MOVE)) begin
        next_st.undef = 1'b1;
        next_st.ld = 1'b0;
        // not executed, so no completion and the last count stays
        next_st.done = 1'b0;
        next_st.cyc = st.cyc;
      end
    end
    next_st.rdy = (next_st.fsm == S_IDLE) || (next_st.fsm == S_EXT);
  end

  // single state register; status flag holds across every transfer
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st <= '0;
      st.fsm <= S_IDLE;
      st.rdy <= 1'b1;
      st.sr <= SR_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign fetch_ready = st.rdy;
  assign mem_req = st.mem;
  assign status_reg = st.sr;
  assign insn_done = st.done;
  assign insn_cycles = st.cyc;
  assign undef_insn = st.undef;
  assign dsp_issue = st.dsp;
  assign dsp_ops = st.dsp_ops;
  assign dbg_data = st.dbg;
endmodule : cpdm_core
`default_nettype wire

// ===== cpdm_core_asserts.sv
/* port assertions for cpdm_core
   bound from the bench top; one clock domain */
`timescale 1ns/10ps
`default_nettype none
module cpdm_core_asserts #(
  parameter int CW = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // fetch and data bus
  input wire cpdm_pkg::cpdm_fetch_t fetch,
  input wire logic fetch_busy,
  input wire logic fetch_ready,
  input wire cpdm_pkg::cpdm_mreq_t mem_req,
  input wire cpdm_pkg::cpdm_mrsp_t mem_rsp,
  // results
  input wire logic [31:0] status_reg,
  input wire logic insn_done,
  input wire logic [CW-1:0] insn_cycles,
  input wire logic undef_insn,
  input wire logic dsp_issue
);
  import cpdm_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // second halfword of a paired word is not an instruction of its own
  logic pair_open;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pair_open <= 1'b0;
    end else if (fetch.valid && fetch_ready) begin
      pair_open <= !pair_open && fetch.insn[15:12] == OPC_DSP && fetch.insn[11:10] == DSP_PAR;
    end
  end
  // a bus transfer ends, an immediate move is taken
  sequence s_bus_done;
    mem_req.req && mem_rsp.ack;
  endsequence
  sequence s_take_imm;
    fetch.valid && fetch_ready && !pair_open && fetch.insn[15:12] == OPC_IMM;
  endsequence
  a_flag_kept: assert property (status_reg == SR_RESET)
    else $error("status changed");
  a_cycles_min: assert property (insn_done |-> insn_cycles != '0)
    else $error("zero cycles");
  a_req_holds: assert property (mem_req.req && !mem_rsp.ack |=> $stable(mem_req))
    else $error("request moved");
  a_req_drops: assert property (s_bus_done |=> !mem_req.req)
    else $error("request kept");
  a_busy_blocks: assert property ($rose(mem_req.req) |-> !$past(fetch_busy))
    else $error("request in fetch cycle");
  a_done_ack: assert property (s_bus_done |=> insn_done)
    else $error("no completion");
  a_stall_ready: assert property (mem_req.req |-> !fetch_ready)
    else $error("ready while waiting");
  a_imm_single: assert property (s_take_imm |=> insn_done && insn_cycles == CW'(1))
    else $error("immediate not one cycle");
  a_undef_quiet: assert property (undef_insn |-> !insn_done && !dsp_issue)
    else $error("undefined executed");
endmodule : cpdm_core_asserts
`default_nettype wire

// ===== cpdm_mem_model.sv
/* partner: fetch bus owner and data memory
   assumes one open request at a time */
`timescale 1ns/10ps
`default_nettype none
module cpdm_mem_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // fetch and data bus
  input wire cpdm_pkg::cpdm_fetch_t fetch,
  input wire logic fetch_ready,
  output logic fetch_busy,
  input wire cpdm_pkg::cpdm_mreq_t mem_req,
  output cpdm_pkg::cpdm_mrsp_t mem_rsp,
  // wait and contention knobs, read data value
  input wire logic [3:0] lag,
  input wire logic [3:0] busy_len,
  input wire logic [31:0] rd_val
);
  import cpdm_pkg::*;
  logic [3:0] cnt;
  logic [3:0] bc;
  logic tk;
  logic ak;
  assign tk = fetch.valid && fetch_ready && busy_len != 4'h0;
  assign ak = mem_req.req && cnt == lag;
  // wait count per request, fetch hold count per take
  always_ff @(posedge sys_clk) begin
    cnt <= (!nrst || !mem_req.req || ak) ? 4'h0 : cnt + 4'h1;
    bc <= !nrst ? 4'h0 : tk ? busy_len - 4'h1 : bc - 4'(bc != 4'h0);
  end
  // data inverted off the ack cycle so stale reads show
  assign mem_rsp = '{ak, ak ? rd_val : ~rd_val};
  assign fetch_busy = tk || bc != 4'h0;
endmodule : cpdm_mem_model
`default_nettype wire

// ===== cpdm_pkg.sv
/*
  Constants, encodings and carrier types for the data-transfer decoder.
  Assumes a 32-bit register file of sixteen entries and a single core clock.
*/
`default_nettype none
package cpdm_pkg;
  localparam int NREG = 16;
  localparam int XLEN = 32;
  // major opcode nibbles (bits 15:12)
  localparam logic [3:0] OPC_IDX = 4'h0;
  localparam logic [3:0] OPC_LST = 4'h1;
  localparam logic [3:0] OPC_STR = 4'h2;
  localparam logic [3:0] OPC_LLD = 4'h5;
  localparam logic [3:0] OPC_LDR = 4'h6;
  localparam logic [3:0] OPC_DSH = 4'h8;
  localparam logic [3:0] OPC_PCW = 4'h9;
  localparam logic [3:0] OPC_PCL = 4'hD;
  localparam logic [3:0] OPC_IMM = 4'hE;
  localparam logic [3:0] OPC_DSP = 4'hF;
  // sub-codes in bits 11:8 of the short displacement group
  localparam logic [3:0] SUB_STB = 4'h0;
  localparam logic [3:0] SUB_STW = 4'h1;
  localparam logic [3:0] SUB_LDB = 4'h4;
  localparam logic [3:0] SUB_LDW = 4'h5;
  // low-nibble modes, bits 3:2 (LO_MOVE matches the whole nibble), size in bits 1:0
  localparam logic [1:0] LO_PLAIN = 2'h0;
  localparam logic [1:0] LO_STEP = 2'h1;
  localparam logic [1:0] LO_IDXLD = 2'h3;
  localparam logic [3:0] LO_MOVE = 4'h3;
  // bits 11:10 of a signal-processing halfword that open a 32-bit word
  localparam logic [1:0] DSP_PAR = 2'h2;
  localparam logic [3:0] REG_ZERO = 4'h0;
  localparam logic [31:0] SR_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [7:0] CYC_ONE = 8'h01;

  typedef enum logic [1:0] {
    SZ_B = 2'h0,
    SZ_W = 2'h1,
    SZ_L = 2'h2,
    SZ_RSV = 2'h3
  } cpdm_size_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_STALL = 4'b0010,
    S_EXT = 4'b0100,
    S_MEM = 4'b1000
  } cpdm_state_t;

  typedef struct packed {
    logic valid;
    logic [15:0] insn;
    logic [XLEN-1:0] pc;
  } cpdm_fetch_t;

  typedef struct packed {
    logic req;
    logic we;
    cpdm_size_t size;
    logic [XLEN-1:0] addr;
    logic [XLEN-1:0] wdata;
  } cpdm_mreq_t;

  typedef struct packed {
    logic ack;
    logic [XLEN-1:0] rdata;
  } cpdm_mrsp_t;
endpackage : cpdm_pkg
`default_nettype wire

// ===== cpu_data_move_decoder_tb.sv
/* self-checking bench for cpdm_core
   assumes cpdm_mem_model as partner */
`timescale 1ns/10ps
`default_nettype none
module cpu_data_move_decoder_tb;
  import cpdm_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic fetch_busy, fetch_ready, insn_done, undef_insn, dsp_issue, cw, du, dd, held = 1'b0;
  cpdm_fetch_t fetch = '0;
  cpdm_mreq_t mem_req;
  cpdm_mrsp_t mem_rsp;
  cpdm_size_t cs;
  logic [31:0] status_reg, dbg_data, ca, cd, rd_val = '0;
  logic [7:0] insn_cycles, cy;
  logic [3:0] dsp_ops, dbg_sel = '0, lag = '0, busy_len = '0;
  int err_total = 0;
  int comparisons = 0;
  // 8 ns core clock
  always #4 sys_clk = ~sys_clk;
  cpdm_core #(.CW(8)) cpdm_core_i (.sys_clk, .nrst, .fetch, .fetch_busy, .fetch_ready,
    .mem_req, .mem_rsp, .status_reg, .insn_done, .insn_cycles, .undef_insn, .dsp_issue,
    .dsp_ops, .dbg_sel, .dbg_data);
  cpdm_mem_model cpdm_mem_model_i (.sys_clk, .nrst, .fetch, .fetch_ready, .fetch_busy,
    .mem_req, .mem_rsp, .lag, .busy_len, .rd_val);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("counts: %0d checks, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic tmo;
    $display("timeout at %0t", $time);
    err_total++;
    end_sim();
  endtask : tmo
  function automatic logic [31:0] ext(input logic [31:0] v, input int sz);
    return sz == 0 ? {{24{v[7]}}, v[7:0]} : sz == 1 ? {{16{v[15]}}, v[15:0]} : v;
  endfunction : ext
  // issue one halfword, optionally present the next one behind it
  task automatic op(input logic [15:0] h, input logic [15:0] nx = 16'h0, input bit nv = 1'b0,
      input bit wt = 1'b1);
    int k;
    ca = 'x;
    if (!held) begin
      fetch <= '{1'b1, h, 32'h100};
      @(posedge sys_clk);
    end
    held = 1'b0;
    for (k = 0; fetch_ready !== 1'b1 && k < 40; k++) @(posedge sys_clk);
    if (k == 40) tmo();
    if (nv) fetch <= '{1'b1, nx, 32'h100};
    else fetch.valid <= 1'b0;
    held = nv;
    for (k = 0; wt && k < 40; k++) begin
      @(posedge sys_clk);
      if (mem_req.req && mem_rsp.ack) begin
        ca = mem_req.addr;
        cd = mem_req.wdata;
        cw = mem_req.we;
        cs = mem_req.size;
      end
      if (insn_done || undef_insn || dsp_issue) break;
    end
    if (wt && k == 40) tmo();
    {cy, du, dd} = {insn_cycles, undef_insn, dsp_issue};
  endtask : op
  task automatic rr(input logic [3:0] n, input logic [31:0] e);
    dbg_sel <= n;
    repeat (2) @(posedge sys_clk);
    chk(dbg_data, e);
  endtask : rr
  task automatic mc(input logic [31:0] a, input logic w, input cpdm_size_t s);
    chk(ca, a);
    chk({29'h0, cw, cs}, {29'h0, w, s});
  endtask : mc
  task automatic t_imm;
    op(16'hE5FF);
    chk(32'(cy), 32'h1);
    rr(4'h5, 32'hFFFF_FFFF);
    op(16'hEF80);
    rr(4'hF, 32'hFFFF_FF80);
    op(16'hE17F);
    op(16'hE240);
    op(16'hE0F0);
    rr(4'h0, 32'hFFFF_FFF0);
    rd_val <= 32'h0000_8001;
    op(16'h9302);
    mc(32'h104, 1'b0, SZ_W);
    rr(4'h3, 32'hFFFF_8001);
    rd_val <= 32'h8000_0001;
    op(16'hD401);
    mc(32'h104, 1'b0, SZ_L);
    rr(4'h4, 32'h8000_0001);
    $display("immediate and relative done");
  endtask : t_imm
  task automatic t_step;
    int i;
    logic [31:0] r;
    r = 32'h7F;
    rd_val <= 32'h1234_56A5;
    for (i = 0; i < 3; i++) begin
      op(16'h6610 + 16'(i));
      mc(r, 1'b0, cpdm_size_t'(i));
      rr(4'h6, ext(32'h1234_56A5, i));
    end
    for (i = 0; i < 3; i++) begin
      r = r - (32'h1 << i);
      op(16'h2124 + 16'(i));
      mc(r, 1'b1, cpdm_size_t'(i));
      chk(cd, 32'h40);
    end
    rd_val <= 32'hCAFE_8080;
    for (i = 0; i < 3; i++) begin
      op(16'h6714 + 16'(i));
      mc(r, 1'b0, cpdm_size_t'(i));
      rr(4'h7, ext(32'hCAFE_8080, i));
      r = r + (32'h1 << i);
    end
    rr(4'h1, r);
    $display("indirect and stepping done");
  endtask : t_step
  task automatic t_disp;
    op(16'h8012);
    mc(32'h81, 1'b1, SZ_B);
    chk(cd, 32'hFFFF_FFF0);
    op(16'h8112);
    mc(32'h83, 1'b1, SZ_W);
    op(16'h1123);
    mc(32'h8B, 1'b1, SZ_L);
    chk(cd, 32'h40);
    rd_val <= 32'h0000_9001;
    op(16'h8512);
    mc(32'h83, 1'b0, SZ_W);
    rr(4'h0, 32'hFFFF_9001);
    rd_val <= 32'h8765_4321;
    op(16'h5813);
    rr(4'h8, 32'h8765_4321);
    rd_val <= 32'h0000_00C3;
    op(16'h091C);
    mc(32'hFFFF_9080, 1'b0, SZ_B);
    rr(4'h9, 32'hFFFF_FFC3);
    $display("displacement and index done");
  endtask : t_disp
  // load-use stall, bus contention and wait cycles
  task automatic t_stall;
    rd_val <= 32'h0000_1111;
    op(16'h6A12, 16'h6BA3, 1'b1);
    chk(32'(cy), 32'h2);
    op(16'h6BA3);
    chk(32'(cy), 32'h2);
    rr(4'hB, 32'h0000_1111);
    chk(status_reg, SR_RESET);
    lag <= 4'h1;
    busy_len <= 4'h2;
    op(16'h6C12);
    chk(32'(cy), 32'h5);
    lag <= 4'h0;
    busy_len <= 4'h0;
    $display("stall and contention done");
  endtask : t_stall
  task automatic t_misc;
    logic [15:0] bad [4] = '{16'h3123, 16'h7105, 16'h6127, 16'hC000};
    foreach (bad[i]) begin
      op(bad[i]);
      chk(32'(du), 32'h1);
    end
    rr(4'h1, 32'h0000_007F);
    op(16'hF000);
    chk({27'h0, dd, dsp_ops}, 32'h10);
    op(16'hF800, 16'h1234, 1'b1, 1'b0);
    @(posedge sys_clk);
    op(16'h1234);
    chk(32'(dd), 32'h1);
    $display("undefined and signal-processing done");
  endtask : t_misc
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    t_imm();
    t_step();
    t_disp();
    t_stall();
    t_misc();
    end_sim();
  end
endmodule : cpu_data_move_decoder_tb
bind cpdm_core cpdm_core_asserts #(.CW(CW)) cpdm_core_asserts_i (.sys_clk, .nrst, .fetch,
  .fetch_busy, .fetch_ready, .mem_req, .mem_rsp, .status_reg, .insn_done, .insn_cycles,
  .undef_insn, .dsp_issue);
`default_nettype wire
